// file: hw/pfs_port_e_low.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "pfs_consts.svh"

module pfs_port_e_low
  import pfs_pkg::*;
#(
  parameter int OR_PINS = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Device state
  input wire logic [1:0] op_mode,
  input wire logic osc_halt,
  input wire logic sw_standby,
  // Port E pins 3..0
  input wire logic [3:0] pe_in,
  output pfs_drive_t [3:0] pe_drv_q,
  // General port logic
  input wire logic [3:0] port_out,
  input wire logic [3:0] port_oe,
  output logic [3:0] port_pin_q,
  // Timer channel 0 compare/capture A..D
  input wire logic [3:0] tmr_out,
  input wire logic [3:0] tmr_oe,
  output logic [3:0] tmr_in_q,
  // DMA controller
  input wire logic [1:0] dma_tend,
  input wire logic [1:0] dma_req_other,
  output logic [1:0] dma_req_q,
  // OR-merged input group
  input wire logic [OR_PINS-1:0] or_pin_val,
  input wire logic [OR_PINS-1:0] or_pin_sel,
  output logic or_merged_q,
  // Bus request and wait
  input wire logic bus_req_in_n,
  input wire logic ext_wait_in_n,
  output logic bus_req_n_q,
  output logic ext_wait_n_q,
  // Ack/refresh output on PD30 and PE15
  input wire logic [1:0] pd30_func,
  input wire logic [2:0] pe15_func,
  input wire logic irq_accept_n,
  input wire logic refresh_n,
  input wire logic refresh_phase,
  output pfs_drive_t pd30_ack_q,
  output pfs_drive_t pe15_ack_q,
  // High-current group control
  output logic [3:0] float_grp_q,
  output logic [3:0] hold_grp_q
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic pfs_func_t decode_func(input logic [2:0] code);
    pfs_func_t f;
    f = PFS_FN_BAD;
    if (code == `PFS_CODE_PORT)
      f = PFS_FN_PORT;
    else if (code == `PFS_CODE_TIMER)
      f = PFS_FN_TIMER;
    else if (code == `PFS_CODE_ALT)
      f = PFS_FN_ALT;
    return f;
  endfunction

  function automatic logic ack_level(input logic [1:0] mode,
                                     input logic irq_n,
                                     input logic ref_n,
                                     input logic phase);
    logic v;
    v = 1'b1;
    unique case (pfs_ack_t'(mode))
      PFS_ACK_IRQ:
        v = irq_n;
      PFS_ACK_REFRESH:
        v = ref_n;
      PFS_ACK_AUTO:
        v = phase ? ref_n : irq_n;
      PFS_ACK_HIGH:
        v = 1'b1;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] func_sel1_q;
  logic [15:0] func_sel1_d;
  logic [15:0] float_ctrl_q;
  logic [15:0] float_ctrl_d;
  logic [15:0] ack_mode_q;
  logic [15:0] ack_mode_d;

  wire logic hit_func = paddr == `PFS_OFS_FUNC_SEL1;
  wire logic hit_float = paddr == `PFS_OFS_FLOAT_CTRL;
  wire logic hit_ack = paddr == `PFS_OFS_ACK_MODE;
  wire logic mapped = hit_func | hit_float | hit_ack;
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable & pready_q;
  wire logic wr_en = access & pwrite & mapped;
  wire logic [15:0] wdata = pwdata[15:0];

  // Reserved bits dropped on write
  // masked register writes
  assign func_sel1_d = (wr_en & hit_func) ?
                       (wdata & `PFS_FUNC_SEL1_MASK) : func_sel1_q;
  assign float_ctrl_d = (wr_en & hit_float) ?
                        (wdata & `PFS_FLOAT_CTRL_MASK) : float_ctrl_q;
  assign ack_mode_d = (wr_en & hit_ack) ?
                      (wdata & `PFS_ACK_MODE_MASK) : ack_mode_q;

  wire logic [15:0] rd_sel = hit_func ? func_sel1_q :
                             hit_float ? float_ctrl_q :
                             hit_ack ? ack_mode_q : 16'h0000;
  wire logic [31:0] prdata_d = setup ? {16'h0000, rd_sel} : prdata_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      func_sel1_q <= `PFS_FUNC_SEL1_RST;
      float_ctrl_q <= `PFS_FLOAT_CTRL_RST;
      ack_mode_q <= `PFS_ACK_MODE_RST;
    end
    else
    begin
      func_sel1_q <= func_sel1_d;
      float_ctrl_q <= float_ctrl_d;
      ack_mode_q <= ack_mode_d;
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // No wait state: pready and read data are flopped from the setup cycle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------
  // Mode qualifiers
  // ----------------------------------------
  wire logic single_chip = op_mode == `PFS_MODE_SINGLE_CHIP;

  // ----------------------------------------
  // Pin routing for PE3..PE0
  // ----------------------------------------
  pfs_func_t [3:0] pin_fn;
  pfs_drive_t [3:0] pin_drv_d;
  logic [3:0] tmr_in_d;
  logic [3:0] req_contrib;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      localparam int LSB = gi * `PFS_PIN_FIELD_STRIDE;
      // Odd pins carry transfer-end, even pins DMA request
      localparam bit IS_TEND = (gi % 2) == 1;
      localparam int DMA_CH = gi / 2;

      // Prohibited codes fall back to a released pin
      // unlisted codes undriven
      assign pin_fn[gi] = decode_func(func_sel1_q[LSB+2:LSB]);

      pfs_drive_t drv;
      always_comb
      begin
        drv = '{out: 1'b0, oe: 1'b0};
        unique case (pin_fn[gi])
          PFS_FN_PORT:
            drv = '{out: port_out[gi], oe: port_oe[gi]};
          PFS_FN_TIMER:
            drv = '{out: tmr_out[gi], oe: tmr_oe[gi]};
          PFS_FN_ALT:
            if (IS_TEND)
              drv = '{out: dma_tend[DMA_CH] | single_chip, oe: 1'b1};
            else
              drv = '{out: 1'b0, oe: 1'b0};
          PFS_FN_BAD:
            drv = '{out: 1'b0, oe: 1'b0};
        endcase
      end
      assign pin_drv_d[gi] = drv;

      // Timer sees the pin only when routed to it
      assign tmr_in_d[gi] = (pin_fn[gi] == PFS_FN_TIMER) & pe_in[gi];

      // Unselected pin counts as idle high in the AND merge
      // low pin makes falling edge
      assign req_contrib[gi] = (!IS_TEND && pin_fn[gi] == PFS_FN_ALT) ?
                               pe_in[gi] : 1'b1;
    end
  endgenerate

  wire logic [1:0] dma_req_d = {req_contrib[2] & dma_req_other[1],
                                req_contrib[0] & dma_req_other[0]};

  wire logic or_merged_d = |(or_pin_val & or_pin_sel);

  wire logic bus_req_n_d = single_chip | bus_req_in_n;
  wire logic ext_wait_n_d = single_chip | ext_wait_in_n;

  // ----------------------------------------
  // Ack/refresh output
  // ----------------------------------------
  wire logic pd30_is_ack = pd30_func == `PFS_PD30_ACK_CODE;
  wire logic pe15_is_ack = pe15_func == `PFS_PE15_ACK_CODE;
  wire logic [1:0] pd_mode = ack_mode_q[`PFS_PD_ACK_LSB+1:`PFS_PD_ACK_LSB];
  wire logic [1:0] pe_mode = ack_mode_q[`PFS_PE_ACK_LSB+1:`PFS_PE_ACK_LSB];

  wire logic pd_level = ack_level(pd_mode, irq_accept_n, refresh_n,
                                  refresh_phase);
  wire logic pe_level = ack_level(pe_mode, irq_accept_n, refresh_n,
                                  refresh_phase);

  wire pfs_drive_t pd30_ack_d = pd30_is_ack ?
                                pfs_drive_t'{out: pd_level, oe: 1'b1} :
                                pfs_drive_t'{out: 1'b0, oe: 1'b0};
  wire pfs_drive_t pe15_ack_d = pe15_is_ack ?
                                pfs_drive_t'{out: pe_level, oe: 1'b1} :
                                pfs_drive_t'{out: 1'b0, oe: 1'b0};

  // ----------------------------------------
  // High-current group float and hold
  // ----------------------------------------
  // float per group
  wire logic [3:0] float_grp_d = ~float_ctrl_q[3:0] &
                                 {4{osc_halt | sw_standby}};
  wire logic [3:0] hold_grp_d = float_ctrl_q[3:0] & {4{osc_halt}};

  // ----------------------------------------
  // Output flops: pin drive and samples
  // ----------------------------------------
  // Flopped so pin timing does not hang on decode depth
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pe_drv_q <= '0;
      port_pin_q <= 4'h0;
      tmr_in_q <= 4'h0;
    end
    else
    begin
      pe_drv_q <= pin_drv_d;
      port_pin_q <= pe_in;
      tmr_in_q <= tmr_in_d;
    end
  end

  // ----------------------------------------
  // Output flops: merged inputs
  // ----------------------------------------
  // Requests idle high so reset release makes no false edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dma_req_q <= 2'h3;
      or_merged_q <= 1'b0;
    end
    else
    begin
      dma_req_q <= dma_req_d;
      or_merged_q <= or_merged_d;
    end
  end

  // ----------------------------------------
  // Output flops: bus request and wait
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_req_n_q <= 1'b1;
      ext_wait_n_q <= 1'b1;
    end
    else
    begin
      bus_req_n_q <= bus_req_n_d;
      ext_wait_n_q <= ext_wait_n_d;
    end
  end

  // ----------------------------------------
  // Output flops: ack/refresh pins
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd30_ack_q <= '0;
      pe15_ack_q <= '0;
    end
    else
    begin
      pd30_ack_q <= pd30_ack_d;
      pe15_ack_q <= pe15_ack_d;
    end
  end

  // ----------------------------------------
  // Output flops: high-current groups
  // ----------------------------------------
  // Float and hold are levels; the pad ring acts on them directly
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      float_grp_q <= 4'h0;
      hold_grp_q <= 4'h0;
    end
    else
    begin
      float_grp_q <= float_grp_d;
      hold_grp_q <= hold_grp_d;
    end
  end

endmodule

// file: inc/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PFS_OFS_FUNC_SEL1 12'h000
`define PFS_OFS_FLOAT_CTRL 12'h004
`define PFS_OFS_ACK_MODE 12'h008

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define PFS_FUNC_SEL1_MASK 16'h7773
`define PFS_FLOAT_CTRL_MASK 16'h000F
`define PFS_ACK_MODE_MASK 16'h000F
`define PFS_FUNC_SEL1_RST 16'h0000
`define PFS_FLOAT_CTRL_RST 16'h000F
`define PFS_ACK_MODE_RST 16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFS_PIN_FIELD_STRIDE 4
`define PFS_PD_ACK_LSB 2
`define PFS_PE_ACK_LSB 0

// ----------------------------------------
// Function codes and modes
// ----------------------------------------
`define PFS_CODE_PORT 3'h0
`define PFS_CODE_TIMER 3'h1
`define PFS_CODE_ALT 3'h2
`define PFS_PD30_ACK_CODE 2'h2
`define PFS_PE15_ACK_CODE 3'h3
`define PFS_MODE_SINGLE_CHIP 2'h3

`endif

// file: inc/pfs_pkg.sv
package pfs_pkg;

  typedef enum logic [1:0] {
    PFS_FN_PORT,
    PFS_FN_TIMER,
    PFS_FN_ALT,
    PFS_FN_BAD
  } pfs_func_t;

  typedef enum logic [1:0] {
    PFS_ACK_IRQ,
    PFS_ACK_REFRESH,
    PFS_ACK_AUTO,
    PFS_ACK_HIGH
  } pfs_ack_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pfs_drive_t;

endpackage

// file: testbench/pfs_pin_board.sv
`timescale 1ns/1ps
module pfs_pin_board
  import pfs_pkg::*;
(
  // Chip side
  input wire pfs_drive_t [3:0] drv,
  // Board side
  input wire logic [3:0] ext_lvl,
  output logic [3:0] pin
);
  // Never left open
  // Released pins show the board driver, not a stale chip level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pin[i] = drv[i].oe ? drv[i].out : ext_lvl[i];
  end
endmodule

// file: testbench/pfs_port_e_low_assertions.sv
`timescale 1ns/1ps
module pfs_chk
  import pfs_pkg::*;
#(
  parameter int OR_PINS = 4
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire logic [1:0] op_mode,
  input wire logic osc_halt,
  input wire logic sw_standby,
  input wire logic [3:0] pe_in,
  input wire logic [3:0] tmr_in_q,
  input wire logic [OR_PINS-1:0] or_pin_val,
  input wire logic [OR_PINS-1:0] or_pin_sel,
  input wire logic or_merged_q,
  input wire logic bus_req_in_n,
  input wire logic bus_req_n_q,
  input wire logic ext_wait_n_q,
  input wire logic [2:0] pe15_func,
  input wire pfs_drive_t pe15_ack_q,
  input wire logic [3:0] float_grp_q,
  input wire logic [3:0] hold_grp_q
);
  // Past values are stale for two edges after reset
  logic [1:0] up_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      up_q <= 2'h0;
    else if (!up_q[1])
      up_q <= up_q + 2'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !up_q[1]);
  a_or_merge: assert property (
    or_merged_q == |($past(or_pin_val) & $past(or_pin_sel)))
    else $error("or merge wrong");
  a_single_chip_in: assert property (
    $past(op_mode) == 2'h3 |-> bus_req_n_q && ext_wait_n_q)
    else $error("bus inputs not ignored");
  a_bus_req_pass: assert property (
    $past(op_mode) != 2'h3 |-> bus_req_n_q == $past(bus_req_in_n))
    else $error("bus request not passed");
  a_ack_select: assert property (
    pe15_ack_q.oe == ($past(pe15_func) == 3'h3))
    else $error("ack output select wrong");
  a_float_cause: assert property (
    |float_grp_q |-> $past(osc_halt || sw_standby))
    else $error("float without cause");
  a_halt_covers: assert property (
    $past(osc_halt) |-> (float_grp_q | hold_grp_q) == 4'hF)
    else $error("group neither floated nor held");
  a_group_excl: assert property (
    (float_grp_q & hold_grp_q) == 4'h0)
    else $error("group floated and held");
  a_timer_in: assert property (
    (tmr_in_q & ~$past(pe_in)) == 4'h0)
    else $error("timer input not from pin");
  c_single: cover property ($past(op_mode) == 2'h3);
  c_ack: cover property (pe15_ack_q.oe);
  c_hold: cover property (|hold_grp_q);
endmodule

bind pfs_port_e_low pfs_chk #(.OR_PINS(OR_PINS)) chk_u (.clock, .rst_n,
  .op_mode, .osc_halt, .sw_standby, .pe_in, .tmr_in_q, .or_pin_val,
  .or_pin_sel, .or_merged_q, .bus_req_in_n, .bus_req_n_q, .ext_wait_n_q,
  .pe15_func, .pe15_ack_q, .float_grp_q, .hold_grp_q);

// file: testbench/port_e_low_pin_function_select_bench.sv
`timescale 1ns/1ps
module port_e_low_pin_function_select_bench
  import pfs_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n, psel, penable, pwrite, pready_q, pslverr_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q;
  logic [45:0] stim;
  logic [3:0] port_out, port_oe, tmr_out, tmr_oe, or_pin_val, or_pin_sel;
  logic [3:0] ext_lvl, pe_in, port_pin_q, tmr_in_q, float_grp_q, hold_grp_q;
  logic [1:0] dma_tend, dma_req_other, pd30_func, op_mode, dma_req_q;
  logic [2:0] pe15_func;
  logic bus_req_in_n, ext_wait_in_n, irq_accept_n, refresh_n, refresh_phase;
  logic osc_halt, sw_standby, or_merged_q, bus_req_n_q, ext_wait_n_q;
  pfs_drive_t [3:0] pe_drv_q;
  pfs_drive_t pd30_ack_q, pe15_ack_q;
  int sel_m = 0, flt_m = 15, ack_m = 0, compares = 0, miscompares = 0;
  int cyc = 0;
  assign {op_mode, port_out, port_oe, tmr_out, tmr_oe, or_pin_val,
    or_pin_sel, ext_lvl, dma_tend, dma_req_other, pd30_func, pe15_func,
    bus_req_in_n, ext_wait_in_n, irq_accept_n, refresh_n, refresh_phase,
    osc_halt, sw_standby} = stim;
  pfs_port_e_low dut_u (.clock, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata_q, .pready_q, .pslverr_q, .op_mode, .osc_halt,
    .sw_standby, .pe_in, .pe_drv_q, .port_out, .port_oe, .port_pin_q,
    .tmr_out, .tmr_oe, .tmr_in_q, .dma_tend, .dma_req_other, .dma_req_q,
    .or_pin_val, .or_pin_sel, .or_merged_q, .bus_req_in_n, .ext_wait_in_n,
    .bus_req_n_q, .ext_wait_n_q, .pd30_func, .pe15_func, .irq_accept_n,
    .refresh_n, .refresh_phase, .pd30_ack_q, .pe15_ack_q, .float_grp_q,
    .hold_grp_q);
  pfs_pin_board brd_u (.drv(pe_drv_q), .ext_lvl, .pin(pe_in));
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    // Answer is taken at the edge that samples pready high
    do
      @(posedge clock);
    while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, s);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input int e, input logic er);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    cmp("read_data", e, rd);
    cmp("slverr", er, err);
  endtask
  function automatic logic ack(input int m);
    case (m)
      0: return irq_accept_n;
      1: return refresh_n;
      2: return refresh_phase ? refresh_n : irq_accept_n;
      default: return 1'b1;
    endcase
  endfunction
  task automatic chk_pins();
    logic [3:0] eo, eoe, lvl, tm, dout, doe;
    logic [1:0] rq, ao;
    int c;
    for (int i = 0; i < 4; i++)
    begin
      c = (sel_m >> (4 * i)) & 7;
      eo[i] = c == 0 ? port_out[i] : c == 1 ? tmr_out[i]
        : op_mode == 2'h3 || dma_tend[i / 2];
      eoe[i] = c == 0 ? port_oe[i] : c == 1 ? tmr_oe[i] : c == 2 && i % 2;
      lvl[i] = eoe[i] ? eo[i] : ext_lvl[i];
      tm[i] = c == 1 && lvl[i];
      dout[i] = pe_drv_q[i].out & pe_drv_q[i].oe;
      doe[i] = pe_drv_q[i].oe;
      if (i % 2 == 0)
        rq[i / 2] = dma_req_other[i / 2] & (c == 2 ? lvl[i] : 1'b1);
    end
    ao = {ack(ack_m >> 2 & 3) & pd30_func == 2'h2,
      ack(ack_m & 3) & pe15_func == 3'h3};
    cmp("pe_drive", {eoe, eo & eoe}, {doe, dout});
    cmp("pin_inputs", {lvl, tm, rq, |(or_pin_val & or_pin_sel)},
      {port_pin_q, tmr_in_q, dma_req_q, or_merged_q});
    cmp("bus_inputs", {2{op_mode == 2'h3}} | {bus_req_in_n, ext_wait_in_n},
      {bus_req_n_q, ext_wait_n_q});
    cmp("ack_out", {pd30_func == 2'h2, pe15_func == 3'h3, ao},
      {pd30_ack_q.oe, pe15_ack_q.oe, pd30_ack_q.out & pd30_ack_q.oe,
      pe15_ack_q.out & pe15_ack_q.oe});
    cmp("float", ~flt_m[3:0] & {4{osc_halt | sw_standby}},
      float_grp_q);
    if (!sw_standby)
      cmp("hold", flt_m[3:0] & {4{osc_halt}}, hold_grp_q);
  endtask
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [63:0] r;
    logic [31:0] rd;
    logic err;
    int v, f, a;
    stim = '0;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(26082));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    apb(1'b1, 12'h00C, 32'h0000FFFF, rd, err);
    cmp("wr_slverr", 1'b1, err);
    rd_chk(12'h000, 0, 1'b0);
    rd_chk(12'h004, 15, 1'b0);
    rd_chk(12'h008, 0, 1'b0);
    rd_chk(12'h00C, 0, 1'b1);
    for (int k = 0; k < 300; k++)
    begin
      r = {$urandom, $urandom};
      stim <= r[45:0];
      v = 0;
      for (int i = 0; i < 4; i++)
        v |= ($urandom % (r[45:44] == 2'h3 && i % 2 ? 2 : 3)) << (4 * i);
      f = $urandom % 16;
      a = $urandom % 16;
      apb(1'b1, 12'h000, v, rd, err);
      apb(1'b1, 12'h004, f, rd, err);
      apb(1'b1, 12'h008, a, rd, err);
      sel_m = v;
      flt_m = f;
      ack_m = a;
      rd_chk(12'h000, v, 1'b0);
      rd_chk(12'h004, f, 1'b0);
      rd_chk(12'h008, a, 1'b0);
      {psel, penable} <= 2'b00;
      repeat (5) @(posedge clock);
      @(negedge clock);
      chk_pins();
      @(posedge clock);
    end
    // Mid-run reset: outputs and registers back to defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp("reset_pins", 16'h0000, {pe_drv_q, port_pin_q, tmr_in_q});
    cmp("reset_misc", {2'h3, 1'b0, 2'h3, 12'h000}, {dma_req_q, or_merged_q,
      bus_req_n_q, ext_wait_n_q, pd30_ack_q, pe15_ack_q, float_grp_q,
      hold_grp_q});
    @(posedge clock);
    rst_n <= 1'b1;
    sel_m = 0;
    flt_m = 15;
    ack_m = 0;
    @(posedge clock);
    rd_chk(12'h000, 0, 1'b0);
    rd_chk(12'h004, 15, 1'b0);
    rd_chk(12'h008, 0, 1'b0);
    {psel, penable} <= 2'b00;
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk_pins();
    @(posedge clock);
    report_and_stop();
  end
endmodule
